// ---- inc/csfbs_pkg.sv ----
// constants for the cpu state flag word and banked register set
`default_nettype none
package csfbs_pkg;
  // ------------------------------------------------------------
  // flag word layout
  // ------------------------------------------------------------
  localparam int FLAG_W = 11;
  localparam int FLAG_C = 0;
  localparam int FLAG_D = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_S = 3;
  localparam int FLAG_B = 4;
  localparam int FLAG_O = 5;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 11'h000;
  // bits of the update mask that the execution logic supplies
  localparam int UPD_W = 4;
  localparam int UPD_C = 0;
  localparam int UPD_Z = 1;
  localparam int UPD_S = 2;
  localparam int UPD_O = 3;
  // ------------------------------------------------------------
  // banked registers
  // ------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int NUM_BANKS = 2;
  localparam int BANK_REGS = 7;
  localparam int IDX_W = 3;
  localparam logic [IDX_W-1:0] IDX_DATA_REG_ZERO = 3'h0;
  localparam logic [IDX_W-1:0] IDX_DATA_REG_ONE = 3'h1;
  localparam logic [IDX_W-1:0] IDX_DATA_REG_TWO = 3'h2;
  localparam logic [IDX_W-1:0] IDX_DATA_REG_THREE = 3'h3;
  localparam logic [IDX_W-1:0] IDX_ADDR_REG_ZERO = 3'h4;
  localparam logic [IDX_W-1:0] IDX_ADDR_REG_ONE = 3'h5;
  localparam logic [IDX_W-1:0] IDX_FRAME_BASE_POINTER = 3'h6;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CPU_STATE_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LAST_RESULT = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- logic/csfbs_bank_file.sv ----
// two whole banks of data, address and frame base registers
`timescale 1ns/1ns
`default_nettype none
module csfbs_bank_file #(
  parameter int DATA_W = 16,
  parameter int NUM_BANKS = 2,
  parameter int BANK_REGS = 7,
  parameter int IDX_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bank choice
  input wire logic bank_sel,
  // write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  // read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_data
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] regs_reg [NUM_BANKS][BANK_REGS];
  logic [DATA_W-1:0] rd_data_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        for (int i = 0; i < BANK_REGS; i++)
        begin
          regs_reg[b][i] <= '0;
        end
      end
    end
    else if (wr_en && (int'(wr_idx) < BANK_REGS))
    begin
      regs_reg[bank_sel][wr_idx] <= wr_data;
    end
  end

  // indices past the last register read as zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_reg <= '0;
    end
    else if (int'(rd_idx) < BANK_REGS)
    begin
      rd_data_reg <= regs_reg[bank_sel][rd_idx];
    end
    else
    begin
      rd_data_reg <= '0;
    end
  end

  assign rd_data = rd_data_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  bank_readback_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_en && (int'(wr_idx) < BANK_REGS))
      ##1 (!wr_en && rd_idx == $past(wr_idx) && bank_sel == $past(bank_sel))
      |=> rd_data == $past(wr_data, 2))
    else $error("banked register did not read back its written value");
endmodule
`default_nettype wire

// ---- logic/csfbs_top.sv ----
// cpu state flag word with register bank select and axi4-lite access
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Function
// - flag word is eleven bits wide
// - carry keeps alu carry, borrow or shift-out
// - zero flag set for a zero result
// - sign flag follows result msb
// - bank flag picks register bank zero or one
// - overflow flag set on signed overflow
// - bank holds four data, two address, frame base
// - exactly two whole banked register sets
module csfbs_top (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [csfbs_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [csfbs_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // execution write-back
  input wire logic EXE_WB,
  input wire logic [csfbs_pkg::DATA_W-1:0] EXE_RESULT,
  input wire logic EXE_CARRY,
  input wire logic EXE_OVERFLOW,
  input wire logic [csfbs_pkg::UPD_W-1:0] EXE_FLAG_UPD,
  input wire logic EXE_DEST_WR,
  input wire logic [csfbs_pkg::IDX_W-1:0] EXE_DEST_IDX,
  // operand read
  input wire logic [csfbs_pkg::IDX_W-1:0] REG_RD_IDX,
  output logic [csfbs_pkg::DATA_W-1:0] REG_RD_DATA,
  // state
  output logic [csfbs_pkg::FLAG_W-1:0] CPU_STATE_FLAGS,
  output logic BANK_SEL
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [csfbs_pkg::FLAG_W-1:0] flags_reg;
  logic [csfbs_pkg::FLAG_W-1:0] flags_next;
  logic [csfbs_pkg::DATA_W-1:0] result_reg;
  logic aw_held_reg;
  logic [csfbs_pkg::ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic sw_flag_wr;
  logic [csfbs_pkg::ADDR_W-1:0] wr_word;
  logic [csfbs_pkg::ADDR_W-1:0] rd_word;

  assign wr_word = {aw_addr_reg[csfbs_pkg::ADDR_W-1:2], 2'h0};
  assign rd_word = {S_AXI_ARADDR[csfbs_pkg::ADDR_W-1:2], 2'h0};
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign sw_flag_wr = do_write && (wr_word == csfbs_pkg::OFS_CPU_STATE_FLAGS);

  // ------------------------------------------------------------
  // flag word
  // ------------------------------------------------------------
  // the debug flag is stored as written; keeping it clear is up to software
  always_comb
  begin
    flags_next = flags_reg;
    if (sw_flag_wr && w_strb_reg[0])
      flags_next[7:0] = w_data_reg[7:0];
    if (sw_flag_wr && w_strb_reg[1])
      flags_next[csfbs_pkg::FLAG_W-1:8] = w_data_reg[csfbs_pkg::FLAG_W-1:8];
    // core write-back overrides a software write landing in the same cycle, for the flag bits its update mask selects
    if (EXE_WB && EXE_FLAG_UPD[csfbs_pkg::UPD_C])
      flags_next[csfbs_pkg::FLAG_C] = EXE_CARRY;
    if (EXE_WB && EXE_FLAG_UPD[csfbs_pkg::UPD_Z])
      flags_next[csfbs_pkg::FLAG_Z] = (EXE_RESULT == '0);
    if (EXE_WB && EXE_FLAG_UPD[csfbs_pkg::UPD_S])
      flags_next[csfbs_pkg::FLAG_S] = EXE_RESULT[csfbs_pkg::DATA_W-1];
    if (EXE_WB && EXE_FLAG_UPD[csfbs_pkg::UPD_O])
      flags_next[csfbs_pkg::FLAG_O] = EXE_OVERFLOW;
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      flags_reg <= csfbs_pkg::FLAG_RESET;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      result_reg <= '0;
    end
    else if (EXE_WB)
    begin
      result_reg <= EXE_RESULT;
    end
  end

  assign CPU_STATE_FLAGS = flags_reg;
  assign BANK_SEL = flags_reg[csfbs_pkg::FLAG_B];

  // ------------------------------------------------------------
  // banked registers
  // ------------------------------------------------------------
  // result and flags are written back on the same edge
  csfbs_bank_file #(
    .DATA_W(csfbs_pkg::DATA_W),
    .NUM_BANKS(csfbs_pkg::NUM_BANKS),
    .BANK_REGS(csfbs_pkg::BANK_REGS),
    .IDX_W(csfbs_pkg::IDX_W)
  ) u_bank_file (
    .clk(MCLK),
    .arst_n(ARST_N),
    .bank_sel(flags_reg[csfbs_pkg::FLAG_B]),
    .wr_en(EXE_WB && EXE_DEST_WR),
    .wr_idx(EXE_DEST_IDX),
    .wr_data(EXE_RESULT),
    .rd_idx(REG_RD_IDX),
    .rd_data(REG_RD_DATA)
  );

  // ------------------------------------------------------------
  // axi4-lite write side
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (S_AXI_AWVALID && !aw_held_reg)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end
    else if (do_write)
    begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (S_AXI_WVALID && !w_held_reg)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_strb_reg <= S_AXI_WSTRB;
    end
    else if (do_write)
    begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= csfbs_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      if (wr_word == csfbs_pkg::OFS_CPU_STATE_FLAGS)
      begin
        bresp_reg <= csfbs_pkg::RESP_OKAY;
      end
      else
      begin
        bresp_reg <= csfbs_pkg::RESP_SLVERR;
      end
    end
    else if (S_AXI_BREADY)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = !aw_held_reg;
  assign S_AXI_WREADY = !w_held_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // ------------------------------------------------------------
  // axi4-lite read side
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= csfbs_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      if (rd_word == csfbs_pkg::OFS_CPU_STATE_FLAGS)
      begin
        rdata_reg <= {21'h000000, flags_reg};
        rresp_reg <= csfbs_pkg::RESP_OKAY;
      end
      else if (rd_word == csfbs_pkg::OFS_LAST_RESULT)
      begin
        rdata_reg <= {16'h0000, result_reg};
        rresp_reg <= csfbs_pkg::RESP_OKAY;
      end
      else
      begin
        rdata_reg <= '0;
        rresp_reg <= csfbs_pkg::RESP_SLVERR;
      end
    end
    else if (S_AXI_RREADY)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  flag_sw_write_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (sw_flag_wr && w_strb_reg[1:0] == 2'h3 && !EXE_WB)
      |=> CPU_STATE_FLAGS == $past(w_data_reg[10:0]))
    else $error("flag word did not take the software write");
  carry_capture_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (EXE_WB && EXE_FLAG_UPD[0]) |=> CPU_STATE_FLAGS[0] == $past(EXE_CARRY))
    else $error("carry flag missed the alu carry");
  zero_flag_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (EXE_WB && EXE_FLAG_UPD[1]) |=> CPU_STATE_FLAGS[2] == ($past(EXE_RESULT) == 16'h0000))
    else $error("zero flag wrong for result");
  sign_flag_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (EXE_WB && EXE_FLAG_UPD[2]) |=> CPU_STATE_FLAGS[3] == $past(EXE_RESULT[15]))
    else $error("sign flag does not follow result msb");
  overflow_flag_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (EXE_WB && EXE_FLAG_UPD[3]) |=> CPU_STATE_FLAGS[5] == $past(EXE_OVERFLOW))
    else $error("overflow flag missed the alu overflow");
  bank_select_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (sw_flag_wr && w_strb_reg[0] && !EXE_WB) |=> BANK_SEL == $past(w_data_reg[4]))
    else $error("bank select did not follow the flag write");
  flags_hold_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (!sw_flag_wr && !(EXE_WB && EXE_FLAG_UPD != 4'h0)) |=> $stable(CPU_STATE_FLAGS))
    else $error("flag word changed without a cause");
endmodule
`default_nettype wire

// ---- tb/csfbs_exec_model.sv ----
// execution unit model that feeds alu results into the flag word
`timescale 1ns/1ns
`default_nettype none
module csfbs_exec_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // command from the bench
  input wire logic go,
  input wire logic [1:0] op,
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic [3:0] upd,
  input wire logic dw,
  input wire logic [2:0] di,
  // write-back towards the flag word
  output logic wb,
  output logic [15:0] res,
  output logic cy,
  output logic ov,
  output logic [3:0] upd_o,
  output logic dw_o,
  output logic [2:0] di_o
);
  logic [16:0] sum;
  logic ovf;
  // op 0 add, 1 subtract, else shift left
  always_comb
  begin
    case (op)
      2'h0: sum = {1'b0, a} + {1'b0, b};
      2'h1: sum = {1'b0, a} - {1'b0, b};
      default: sum = {a, 1'b0};
    endcase
    ovf = (sum[15] != a[15]) && (op == 2'h2 || ((a[15] == b[15]) == (op == 2'h0)));
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb <= 1'b0;
      res <= 16'h0000;
      cy <= 1'b0;
      ov <= 1'b0;
      upd_o <= 4'h0;
      dw_o <= 1'b0;
      di_o <= 3'h0;
    end
    else
    begin
      wb <= go;
      // fields turn over between write-backs so a stale value never passes
      res <= go ? sum[15:0] : ~res;
      cy <= go ? sum[16] : ~cy;
      ov <= go ? ovf : ~ov;
      upd_o <= go ? upd : ~upd_o;
      dw_o <= go ? dw : ~dw_o;
      di_o <= go ? di : ~di_o;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_cpu_status_flags_bank_select.sv ----
// self-checking bench for the flag word and banked registers
`timescale 1ns/1ns
`default_nettype none
module test_cpu_status_flags_bank_select;
  logic mclk, arst_n, awv, wv, bre, arv, rre, go, dw;
  logic awr, wrdy, bv, arr, rv, ewb, ecy, eov, edw, bsel;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata;
  logic [3:0] ws, upd, eupd;
  logic [1:0] op, bresp, rresp;
  logic [15:0] a, b, eres, rdd;
  logic [2:0] di, ri, edi;
  logic [10:0] flags, ef;
  int error_cnt, comparisons;
  csfbs_top uut (.MCLK(mclk), .ARST_N(arst_n),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .EXE_WB(ewb), .EXE_RESULT(eres), .EXE_CARRY(ecy), .EXE_OVERFLOW(eov),
    .EXE_FLAG_UPD(eupd), .EXE_DEST_WR(edw), .EXE_DEST_IDX(edi),
    .REG_RD_IDX(ri), .REG_RD_DATA(rdd), .CPU_STATE_FLAGS(flags), .BANK_SEL(bsel));
  csfbs_exec_model core (.clk(mclk), .arst_n(arst_n), .go(go), .op(op), .a(a), .b(b),
    .upd(upd), .dw(dw), .di(di), .wb(ewb), .res(eres), .cy(ecy), .ov(eov),
    .upd_o(eupd), .dw_o(edw), .di_o(edi));
  always #5 mclk = ~mclk;
  // ------------------------------------------------------------
  // checks and transfers
  // ------------------------------------------------------------
  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    $display("CHECK FAILED %0t bus wait ran out", $time);
    conclude();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cmpr(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t response got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] st,
    input logic [1:0] er);
    logic aw, w, bd;
    logic [1:0] rs;
    int n;
    aw = 1'b1;
    w = 1'b1;
    bd = 1'b0;
    n = 0;
    @(posedge mclk);
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    awa <= ad;
    wd <= d;
    ws <= st;
    while (!bd && n < 60)
    begin
      @(negedge mclk);
      aw = aw && !awr;
      w = w && !wrdy;
      bd = bv === 1'b1;
      rs = bresp;
      @(posedge mclk);
      awv <= aw;
      wv <= w;
      bre <= !bd;
      n++;
    end
    if (!bd)
      tmo();
    @(negedge mclk);
    cmpr(rs, er);
    if (ad[7:2] == 6'h00 && st[0])
      ef[7:0] = d[7:0];
    if (ad[7:2] == 6'h00 && st[1])
      ef[10:8] = d[10:8];
    cmp(32'(flags), 32'(ef), "flags after write");
    cmp(32'(bsel), 32'(ef[csfbs_pkg::FLAG_B]), "bank select");
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    logic ar, got;
    logic [31:0] dat;
    logic [1:0] rs;
    int n;
    ar = 1'b1;
    got = 1'b0;
    n = 0;
    @(posedge mclk);
    arv <= 1'b1;
    rre <= 1'b1;
    ara <= ad;
    while (!got && n < 60)
    begin
      @(negedge mclk);
      ar = ar && !arr;
      got = rv === 1'b1;
      dat = rdata;
      rs = rresp;
      @(posedge mclk);
      arv <= ar;
      rre <= !got;
      n++;
    end
    if (!got)
      tmo();
    cmpr(rs, er);
    cmp(dat, ed, "read data");
  endtask
  // e holds the expected {O,S,Z,C}; d holds {dest write, dest index}
  task automatic alu(input logic [1:0] o, input logic [15:0] x, input logic [15:0] y,
    input logic [3:0] u, input logic [3:0] e, input logic [3:0] d);
    @(posedge mclk);
    go <= 1'b1;
    op <= o;
    a <= x;
    b <= y;
    upd <= u;
    dw <= d[3];
    di <= d[2:0];
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    if (u[csfbs_pkg::UPD_C])
      ef[csfbs_pkg::FLAG_C] = e[0];
    if (u[csfbs_pkg::UPD_Z])
      ef[csfbs_pkg::FLAG_Z] = e[1];
    if (u[csfbs_pkg::UPD_S])
      ef[csfbs_pkg::FLAG_S] = e[2];
    if (u[csfbs_pkg::UPD_O])
      ef[csfbs_pkg::FLAG_O] = e[3];
    cmp(32'(flags), 32'(ef), "flags after op");
  endtask
  task automatic rr(input logic [2:0] i, input logic [15:0] e);
    @(posedge mclk);
    ri <= i;
    @(posedge mclk);
    @(negedge mclk);
    cmp(32'(rdd), 32'(e), "banked reg");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {mclk, arst_n, awv, wv, bre, arv, rre, go, dw} = '0;
    {awa, ara, wd, ws, upd, op, a, b, di, ri} = '0;
    ef = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'h00, 32'h0, csfbs_pkg::RESP_OKAY);
    alu(2'h0, 16'h7FFF, 16'h0001, 4'hF, 4'b1100, 4'h0);
    alu(2'h0, 16'hFFFF, 16'h0001, 4'hF, 4'b0011, 4'h0);
    alu(2'h1, 16'h0000, 16'h0001, 4'hF, 4'b0101, 4'h0);
    alu(2'h2, 16'h8000, 16'h0000, 4'hF, 4'b1011, 4'h0);
    alu(2'h0, 16'h0001, 16'h0001, 4'h2, 4'b0000, 4'h0);
    alu(2'h1, 16'h8000, 16'h0001, 4'hF, 4'b1000, 4'h0);
    wr(8'h00, 32'hFFFF_FFED, 4'h3, csfbs_pkg::RESP_OKAY);
    rd(8'h00, 32'h0000_07ED, csfbs_pkg::RESP_OKAY);
    // upper lane alone must leave the low flag byte untouched
    wr(8'h00, 32'h0000_0000, 4'h2, csfbs_pkg::RESP_OKAY);
    rd(8'h00, 32'h0000_00ED, csfbs_pkg::RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, 32'(k) << 4, 4'h1, csfbs_pkg::RESP_OKAY);
      for (int i = 0; i < 8; i++)
        alu(2'h0, 16'((k + 1) * 4096 + i), 16'h0, 4'h0, 4'h0, {1'b1, 3'(i)});
    end
    for (int k = 1; k >= 0; k--)
    begin
      wr(8'h00, 32'(k) << 4, 4'h1, csfbs_pkg::RESP_OKAY);
      for (int i = 0; i < 8; i++)
        rr(3'(i), i == 7 ? 16'h0 : 16'((k + 1) * 4096 + i));
    end
    wr(8'h04, 32'h0000_0005, 4'h3, csfbs_pkg::RESP_SLVERR);
    wr(8'h08, 32'h0000_0005, 4'h3, csfbs_pkg::RESP_SLVERR);
    rd(8'h08, 32'h0, csfbs_pkg::RESP_SLVERR);
    rd(8'h04, 32'h0000_2007, csfbs_pkg::RESP_OKAY);
    // a second reset in mid-run must clear flags and banks again
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    ef = '0;
    rr(3'h0, 16'h0000);
    cmp(32'(flags), 32'h0, "flags after reset");
    conclude();
  end
endmodule
`default_nettype wire
